// ===== hdl/bfm_engine.sv
/*
 * Business field move engine: plain, delimited, blank-fill and zero-fill
 * character moves with indexing, sign handling, condition register,
 * interrupt stop and a progress index register, plus an APB slave.
 * Assumes main control, core storage and the APB master run on SYS_CLK.
 */
// Behaviour
// - Trap business ops other than unit ops from SUB_LOAD up when switch off or absent
// - Finish current character, then return control
// - Save progress for store, reload and resume
// - Binary and decimal conversions restart from their beginning
// - Pack and unpack restart after illegal write
// - Progress low bits count destination characters
// - Progress bit 12 marks a second pass
// - Progress bit 13 holds previous decimal carry
// - Progress bit 14 marks a decimal fault
// - Condition set when the sign character is read, cleared at start
// - Digit low four bits, sign from last zone
// - Zone 10 negative, other zones positive
// - Packed sign nibbles 1010 positive, 1011 negative
// - Index flag selects first, second or none
// - Plain move stops at shorter field
// - Plain and blank moves record moved sign
// - Delimited move stops after delimiter or length
// - Delimited move leaves condition zero
// - Blank-fill pads longer destination with blanks
// - Zero-fill pads zeros, sign in last character
`timescale 1ns/1ps
`default_nettype none
module bfm_engine
    import bfm_pkg::*;
(
    // Clock and reset.
    input wire logic SYS_CLK,
    input wire logic RST,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Instruction hand-over from main control.
    input wire logic START,
    input wire logic [5:0] OPCODE,
    input wire logic [2:0] SUBOP,
    input wire logic DELIM_MODE,
    input wire logic [5:0] DELIM_CHAR,
    input wire logic [16:0] SRC_ADDR,
    input wire logic [1:0] SRC_FLAG,
    input wire logic [16:0] DST_ADDR,
    input wire logic [1:0] DST_FLAG,
    input wire logic [11:0] SRC_LEN,
    input wire logic [11:0] DST_LEN,
    input wire logic [17:0] INDEX1,
    input wire logic [17:0] INDEX2,
    input wire logic MODE_SW,
    input wire logic UNIT_PRESENT,
    input wire logic INT_STOP,
    input wire logic ILLEGAL_WRITE,
    // Completion status to main control.
    output logic BUSY,
    output logic DONE,
    output logic TRAP,
    output logic INTERRUPTED,
    output logic [1:0] RESULT_COND,
    // Character storage port.
    output logic MEM_REQ,
    output logic MEM_WE,
    output logic [17:0] MEM_ADDR,
    output logic [5:0] MEM_WDATA,
    input wire logic [5:0] MEM_RDATA,
    input wire logic MEM_ACK
);

    ////////////////////////////////////////////////////////////////////
    function automatic logic [17:0] eff_addr(input logic [16:0] base,
        input logic [1:0] flg, input logic [17:0] i1, input logic [17:0] i2);
        case (flg)
            2'h0: eff_addr = {1'b0, base};
            2'h2: eff_addr = {1'b0, base} + i2;
            default: eff_addr = {1'b0, base} + i1;
        endcase
    endfunction

    function automatic logic [1:0] sign_of(input logic [1:0] zone);
        sign_of = (zone == ZONE_NEG) ? COND_NEG : COND_POS;
    endfunction

    ////////////////////////////////////////////////////////////////////
    bfm_state_t state_reg;
    logic [2:0] sub_reg;
    logic delim_reg;
    logic [5:0] dchar_reg;
    logic [17:0] ra_reg;
    logic [17:0] sa_reg;
    logic [11:0] len1_reg;
    logic [11:0] len2_reg;
    logic [11:0] nmove_reg;
    logic [11:0] total_reg;
    logic [1:0] zone_reg;
    logic [5:0] src_reg;
    logic delim_hit_reg;
    logic int_pend_reg;
    logic iw_reg;
    logic ctrl_reg;
    logic [14:0] prog_reg;
    logic [1:0] cond_reg;
    logic pready_reg;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic busy_reg;
    logic done_reg;
    logic trap_reg;
    logic intr_reg;
    logic mem_req_reg;
    logic mem_we_reg;
    logic [17:0] mem_addr_reg;
    logic [5:0] mem_wdata_reg;

    logic idle;
    logic is_biz;
    logic unit_op;
    logic start_go;
    logic trap_go;
    logic move_go;
    logic other_go;
    logic restart_top;
    logic ack;
    logic [11:0] cnt;
    logic [11:0] start_cnt;
    logic [11:0] short_len;
    logic fill_phase;
    logic sign_pos;
    logic last_pos;
    logic bad_char;
    logic apb_acc;
    logic apb_wr;
    logic [5:0] wdata_next;

    assign idle = (state_reg == ST_IDLE);
    assign is_biz = (OPCODE >= OP_FIRST) && (OPCODE <= OP_LAST);
    assign unit_op = (OPCODE == OP_UNIT) && (SUBOP >= SUB_LOAD);
    assign start_go = idle && START && is_biz;
    assign trap_go = start_go && !(MODE_SW && UNIT_PRESENT) && !unit_op;
    assign move_go = start_go && !trap_go && (OPCODE == OP_MOVE) && (SUBOP <= SUB_ZERO);
    assign other_go = start_go && !trap_go && !move_go;
    assign restart_top = (OPCODE == OP_CONV) && ((SUBOP == SUB_TO_BIN)
        || (SUBOP == SUB_TO_BCD)
        || (((SUBOP == SUB_PACK) || (SUBOP == SUB_UNPACK)) && iw_reg));
    assign ack = mem_req_reg && MEM_ACK;
    assign cnt = prog_reg[PROG_CNT_MSB:0];
    assign start_cnt = ctrl_reg ? cnt : 12'h000;
    assign short_len = (SRC_LEN < DST_LEN) ? SRC_LEN : DST_LEN;
    assign fill_phase = (cnt >= nmove_reg);
    assign sign_pos = (cnt == len1_reg - 12'h001);
    assign last_pos = (cnt == len2_reg - 12'h001);
    assign apb_acc = PSEL && PENABLE && !pready_reg;
    assign apb_wr = PSEL && PENABLE && PWRITE && pready_reg;

    // Character moved into the destination; zero fill drops zones and bad
    // digits and puts the field sign into the last destination position.
    always_comb begin
        if (sub_reg == SUB_ZERO) begin
            wdata_next = {ZONE_NONE, (fill_phase || MEM_RDATA[3:0] > DIGIT_MAX)
                ? 4'h0 : MEM_RDATA[3:0]};
            if (last_pos) begin
                wdata_next[5:4] = zone_reg;
            end
        end else if (fill_phase) begin
            wdata_next = BLANK_CHAR;
        end else begin
            wdata_next = MEM_RDATA;
        end
    end

    // Zone must be clear except on the sign character, digits must be
    // decimal except a legal 10 in the sign character.
    assign bad_char = (!sign_pos && MEM_RDATA[5:4] != ZONE_NONE)
        || (MEM_RDATA[3:0] > DIGIT_MAX && !(sign_pos && MEM_RDATA[3:0] == SIGN_DIGIT_OK));

    ////////////////////////////////////////////////////////////////////
    // Instruction sequencer and storage port.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            state_reg <= ST_IDLE;
            sub_reg <= SUB_PLAIN;
            delim_reg <= 1'b0;
            dchar_reg <= 6'h00;
            ra_reg <= 18'h00000;
            sa_reg <= 18'h00000;
            len1_reg <= 12'h000;
            len2_reg <= 12'h000;
            nmove_reg <= 12'h000;
            total_reg <= 12'h000;
            zone_reg <= ZONE_NONE;
            src_reg <= 6'h00;
            delim_hit_reg <= 1'b0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
            trap_reg <= 1'b0;
            intr_reg <= 1'b0;
            mem_req_reg <= 1'b0;
            mem_we_reg <= 1'b0;
            mem_addr_reg <= 18'h00000;
            mem_wdata_reg <= 6'h00;
        end else begin
            done_reg <= 1'b0;
            trap_reg <= trap_go;
            intr_reg <= 1'b0;
            if (ack) begin
                mem_req_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (move_go) begin
                        sub_reg <= SUBOP;
                        delim_reg <= DELIM_MODE && (SUBOP == SUB_PLAIN);
                        dchar_reg <= DELIM_CHAR;
                        ra_reg <= eff_addr(SRC_ADDR, SRC_FLAG, INDEX1, INDEX2);
                        sa_reg <= eff_addr(DST_ADDR, DST_FLAG, INDEX1, INDEX2);
                        len1_reg <= SRC_LEN;
                        len2_reg <= DST_LEN;
                        zone_reg <= ZONE_NONE;
                        delim_hit_reg <= 1'b0;
                        busy_reg <= 1'b1;
                        if (DELIM_MODE && SUBOP == SUB_PLAIN) begin
                            nmove_reg <= DST_LEN;
                            total_reg <= DST_LEN;
                        end else begin
                            nmove_reg <= short_len;
                            total_reg <= (SUBOP == SUB_PLAIN) ? short_len : DST_LEN;
                        end
                        if (SUBOP == SUB_ZERO && SRC_LEN != 12'h000) begin
                            state_reg <= ST_SIGN;
                            mem_req_reg <= 1'b1;
                            mem_we_reg <= 1'b0;
                            mem_addr_reg <= eff_addr(SRC_ADDR, SRC_FLAG, INDEX1, INDEX2)
                                + {6'h00, SRC_LEN - 12'h001};
                        end else begin
                            state_reg <= ST_NEXT;
                        end
                    end else if (other_go) begin
                        done_reg <= 1'b1;
                    end
                end
                ST_SIGN: begin
                    if (ack) begin
                        zone_reg <= MEM_RDATA[5:4];
                        state_reg <= ST_NEXT;
                    end
                end
                ST_NEXT: begin
                    if (int_pend_reg) begin
                        intr_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (delim_hit_reg || cnt >= total_reg) begin
                        done_reg <= 1'b1;
                        busy_reg <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (!fill_phase) begin
                        state_reg <= ST_READ;
                        mem_req_reg <= 1'b1;
                        mem_we_reg <= 1'b0;
                        mem_addr_reg <= ra_reg + {6'h00, cnt};
                    end else begin
                        state_reg <= ST_WRITE;
                        mem_req_reg <= 1'b1;
                        mem_we_reg <= 1'b1;
                        mem_addr_reg <= sa_reg + {6'h00, cnt};
                        mem_wdata_reg <= (sub_reg == SUB_ZERO) ? wdata_next : BLANK_CHAR;
                    end
                end
                ST_READ: begin
                    if (ack) begin
                        src_reg <= MEM_RDATA;
                        state_reg <= ST_WRITE;
                        mem_req_reg <= 1'b1;
                        mem_we_reg <= 1'b1;
                        mem_addr_reg <= sa_reg + {6'h00, cnt};
                        mem_wdata_reg <= wdata_next;
                    end
                end
                ST_WRITE: begin
                    if (ack) begin
                        delim_hit_reg <= delim_reg && !fill_phase
                            && (src_reg == dchar_reg);
                        state_reg <= ST_NEXT;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                    busy_reg <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupt stop from main control is held until the character in
    // flight completes; the illegal-write cause is kept for restart.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            int_pend_reg <= 1'b0;
            iw_reg <= 1'b0;
        end else if (move_go) begin
            int_pend_reg <= 1'b0;
        end else if (!idle && INT_STOP && !int_pend_reg) begin
            int_pend_reg <= 1'b1;
            iw_reg <= ILLEGAL_WRITE;
        end else if (intr_reg) begin
            int_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Progress index: count, pass, carry and fault.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            prog_reg <= PROG_RESET;
        end else if ((move_go && !ctrl_reg) || (other_go && restart_top)) begin
            prog_reg <= PROG_RESET;
        end else if (move_go) begin
            prog_reg <= {prog_reg[PROG_FAULT_BIT], 1'b0, prog_reg[PROG_PASS_BIT], start_cnt};
        end else if (state_reg == ST_WRITE && ack) begin
            prog_reg[PROG_CNT_MSB:0] <= cnt + 12'h001;
        end else if (state_reg == ST_READ && ack && sub_reg == SUB_ZERO && bad_char) begin
            prog_reg[PROG_FAULT_BIT] <= 1'b1;
        end else if (state_reg == ST_SIGN && ack && MEM_RDATA == SIGN_BAD_CHAR) begin
            prog_reg[PROG_FAULT_BIT] <= 1'b1;
        end else if (state_reg == ST_NEXT && int_pend_reg) begin
            prog_reg[PROG_PASS_BIT] <= fill_phase;
            prog_reg[PROG_CARRY_BIT] <= 1'b0;
        end else if (idle && apb_wr && PADDR == REG_PROG_OFF) begin
            prog_reg <= PWDATA[14:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Result condition.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            cond_reg <= COND_RESET;
        end else if (start_go && !trap_go && !unit_op) begin
            cond_reg <= COND_RESET;
        end else if (state_reg == ST_SIGN && ack) begin
            cond_reg <= sign_of(MEM_RDATA[5:4]);
        end else if (state_reg == ST_READ && ack && sign_pos && !delim_reg
            && sub_reg != SUB_ZERO) begin
            cond_reg <= sign_of(MEM_RDATA[5:4]);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, writes land at the edge with PREADY high.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pslverr_reg <= 1'b0;
            ctrl_reg <= CTRL_RESET;
        end else begin
            pready_reg <= apb_acc;
            if (apb_acc) begin
                pslverr_reg <= 1'b0;
                case (PADDR)
                    REG_CTRL_OFF: prdata_reg <= {31'h00000000, ctrl_reg};
                    REG_PROG_OFF: prdata_reg <= {17'h00000, prog_reg};
                    REG_COND_OFF: prdata_reg <= {30'h00000000, cond_reg};
                    REG_STAT_OFF: prdata_reg <= {25'h0000000,
                        (cond_reg == COND_NEG) ? PACK_NEG : PACK_POS,
                        iw_reg, int_pend_reg, busy_reg};
                    default: begin
                        prdata_reg <= 32'h00000000;
                        pslverr_reg <= 1'b1;
                    end
                endcase
            end
            if (apb_wr && PADDR == REG_CTRL_OFF) begin
                ctrl_reg <= PWDATA[CTRL_RESUME_BIT];
            end
        end
    end

    assign PRDATA = prdata_reg;
    assign PREADY = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign BUSY = busy_reg;
    assign DONE = done_reg;
    assign TRAP = trap_reg;
    assign INTERRUPTED = intr_reg;
    assign RESULT_COND = cond_reg;
    assign MEM_REQ = mem_req_reg;
    assign MEM_WE = mem_we_reg;
    assign MEM_ADDR = mem_addr_reg;
    assign MEM_WDATA = mem_wdata_reg;

    ////////////////////////////////////////////////////////////////////
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    property p_trap;
        trap_go |=> TRAP && !BUSY;
    endproperty
    a_trap: assert property (p_trap) else $error("trap not raised");
    property p_stop;
        (state_reg == ST_WRITE && ack && int_pend_reg) |=> ##1 INTERRUPTED && !BUSY;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not after char");
    property p_cnt;
        (state_reg == ST_WRITE && ack) |=> cnt == $past(cnt) + 12'h001;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count not advanced");
    property p_clr;
        move_go |=> RESULT_COND == COND_RESET;
    endproperty
    a_clr: assert property (p_clr) else $error("condition not cleared");
    property p_neg;
        (state_reg == ST_READ && ack && sign_pos && sub_reg == SUB_PLAIN && !delim_reg
            && MEM_RDATA[5:4] == ZONE_NEG) |=> RESULT_COND == COND_NEG;
    endproperty
    a_neg: assert property (p_neg) else $error("negative sign lost");
    property p_ea;
        (move_go && SRC_FLAG == 2'h2) |=> ra_reg == $past({1'b0, SRC_ADDR} + INDEX2);
    endproperty
    a_ea: assert property (p_ea) else $error("bad source index");
    property p_bound;
        (MEM_REQ && MEM_WE) |-> cnt < total_reg;
    endproperty
    a_bound: assert property (p_bound) else $error("write past field");
    property p_dcond;
        (busy_reg && delim_reg) |-> RESULT_COND == COND_RESET;
    endproperty
    a_dcond: assert property (p_dcond) else $error("delimited cond set");
    property p_blank;
        (MEM_REQ && MEM_WE && sub_reg == SUB_BLANK && fill_phase) |-> MEM_WDATA == BLANK_CHAR;
    endproperty
    a_blank: assert property (p_blank) else $error("fill not blank");
    property p_zsign;
        (MEM_REQ && MEM_WE && sub_reg == SUB_ZERO && last_pos) |-> MEM_WDATA[5:4] == zone_reg;
    endproperty
    a_zsign: assert property (p_zsign) else $error("sign not in last");
    c_done: cover property (move_go ##[1:200] DONE);
    c_intr: cover property (move_go ##[1:200] INTERRUPTED);
    c_delim: cover property (delim_hit_reg && state_reg == ST_NEXT);
endmodule
`default_nettype wire

// ===== hdl/bfm_pkg.sv
/*
 * Constants for the business field move engine: register map, field
 * positions, reset values, opcodes, character codes and states.
 * Assumes nothing of its surroundings; imported by the engine.
 */
package bfm_pkg;
    // Register byte offsets on the APB slave.
    localparam logic [7:0] REG_CTRL_OFF = 8'h00;
    localparam logic [7:0] REG_PROG_OFF = 8'h04;
    localparam logic [7:0] REG_COND_OFF = 8'h08;
    localparam logic [7:0] REG_STAT_OFF = 8'h0C;
    // Field positions.
    localparam int CTRL_RESUME_BIT = 0;
    localparam int PROG_CNT_MSB = 11;
    localparam int PROG_PASS_BIT = 12;
    localparam int PROG_CARRY_BIT = 13;
    localparam int PROG_FAULT_BIT = 14;
    // Reset values.
    localparam logic CTRL_RESET = 1'h0;
    localparam logic [14:0] PROG_RESET = 15'h0000;
    localparam logic [1:0] COND_RESET = 2'h0;
    // Opcodes (major part) and sub-operations.
    localparam logic [5:0] OP_FIRST = 6'h34;
    localparam logic [5:0] OP_MOVE = 6'h34;
    localparam logic [5:0] OP_CONV = 6'h36;
    localparam logic [5:0] OP_UNIT = 6'h38;
    localparam logic [5:0] OP_LAST = 6'h38;
    localparam logic [2:0] SUB_PLAIN = 3'h0;
    localparam logic [2:0] SUB_BLANK = 3'h1;
    localparam logic [2:0] SUB_ZERO = 3'h2;
    localparam logic [2:0] SUB_TO_BIN = 3'h0;
    localparam logic [2:0] SUB_TO_BCD = 3'h1;
    localparam logic [2:0] SUB_PACK = 3'h4;
    localparam logic [2:0] SUB_UNPACK = 3'h5;
    localparam logic [2:0] SUB_LOAD = 3'h6;
    // Character codes.
    localparam logic [1:0] ZONE_NEG = 2'h2;
    localparam logic [1:0] ZONE_NONE = 2'h0;
    localparam logic [1:0] COND_POS = 2'h0;
    localparam logic [1:0] COND_NEG = 2'h2;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] SIGN_DIGIT_OK = 4'hA;
    localparam logic [5:0] SIGN_BAD_CHAR = 6'h3A;
    localparam logic [5:0] BLANK_CHAR = 6'h10;
    localparam logic [3:0] PACK_POS = 4'hA;
    localparam logic [3:0] PACK_NEG = 4'hB;
    // Engine states.
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_SIGN = 5'b00010,
        ST_NEXT = 5'b00100,
        ST_READ = 5'b01000,
        ST_WRITE = 5'b10000
    } bfm_state_t;
endpackage

// ===== sim/bfm_engine_bench.sv
/* Self-checking bench for the field move engine with a storage model.
   Assumes the engine, its package and the storage model are compiled. */
`timescale 1ns/1ps
`default_nettype none
module bfm_engine_bench;
    import bfm_pkg::*;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, start = 0, dm = 0, msw = 1;
    logic upr = 1, ist = 0, slow = 0, pready, pslverr, busy, done, trap, intr, mreq, mwe, mack;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [17:0] maddr;
    logic [11:0] sl = 0, dl = 0;
    logic [7:0] paddr = 0;
    logic [5:0] opc = 0, dch = 6'h3F, mwd, mrd;
    logic [2:0] sub = 0, fl;
    logic [1:0] srcf = 0, dstf = 0, cond;
    int n_mismatch = 0, checked = 0, cyc = 0, nw = 0, irq_at = -1;
    logic iw = 0, bz = 0;
    bfm_engine bfm_engine_inst (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .START(start), .OPCODE(opc), .SUBOP(sub), .DELIM_MODE(dm),
        .DELIM_CHAR(dch), .SRC_ADDR(17'h00100), .SRC_FLAG(srcf), .DST_ADDR(17'h00800),
        .DST_FLAG(dstf), .SRC_LEN(sl), .DST_LEN(dl), .INDEX1(18'h00020), .INDEX2(18'h00040),
        .MODE_SW(msw), .UNIT_PRESENT(upr), .INT_STOP(ist), .ILLEGAL_WRITE(iw), .BUSY(busy),
        .DONE(done), .TRAP(trap), .INTERRUPTED(intr), .RESULT_COND(cond), .MEM_REQ(mreq),
        .MEM_WE(mwe), .MEM_ADDR(maddr), .MEM_WDATA(mwd), .MEM_RDATA(mrd), .MEM_ACK(mack));
    bfm_store bfm_store_inst (.clk(clk), .slow(slow), .req(mreq), .we(mwe), .addr(maddr),
        .wdata(mwd), .rdata(mrd), .ack(mack));
    ////////////////////////////////////////
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        ist <= cyc == irq_at;
        if (mreq === 1'b1 && mack === 1'b1 && mwe === 1'b1)
            nw <= nw + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            finish_test;
        end
    end
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = pslverr === 1'b1 ? 32'hEEEEEEEE : prdata;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task go(input logic [5:0] op, input logic [2:0] sb);
        opc <= op;
        sub <= sb;
        start <= 1'b1;
        bz = 1'b0;
        @(posedge clk);
        start <= 1'b0;
        do begin
            @(posedge clk);
            bz = bz | busy;
        end while ({trap, intr, done} === 3'b000);
        fl = {trap, intr, done};
        @(posedge clk);
    endtask
    // Lays out both fields, predicts the result, runs the move and compares.
    task mv(input logic [2:0] sb, input logic d, input int l1, l2, input logic [1:0] fr, fs,
            input logic [1:0] zn, input logic it);
        int i, n, a, b, w0, sv;
        logic [5:0] ex [64];
        sv = 0;
        a = 'h100 + (fr == 0 ? 0 : fr == 2 ? 'h40 : 'h20);
        b = 'h800 + (fs == 0 ? 0 : fs == 2 ? 'h40 : 'h20);
        for (i = 0; i < 64; i++) begin
            ex[i] = 6'($urandom);
            bfm_store_inst.mem[b + i] = ex[i];
        end
        for (i = 0; i < l1; i++)
            bfm_store_inst.mem[a + i] = {i == l1 - 1 ? zn : 2'h0, 4'($urandom % 10)};
        if (d)
            bfm_store_inst.mem[a + l1 - 1] = dch;
        if (sb == 2 && zn == 3)
            bfm_store_inst.mem[a + l1 - 1] = SIGN_BAD_CHAR;
        n = l1 < l2 ? l1 : l2;
        for (i = 0; i < l2; i++)
            if (i < n)
                ex[i] = bfm_store_inst.mem[a + i] & (sb == 2 ? 6'h0F : 6'h3F);
            else if (sb != 0)
                ex[i] = sb == 1 ? BLANK_CHAR : 6'h00;
        if (sb == 2)
            ex[l2 - 1][5:4] = zn;
        srcf <= fr;
        dstf <= fs;
        sl <= d ? 12'h000 : 12'(l1);
        dl <= 12'(l2);
        dm <= d;
        w0 = nw;
        irq_at <= it ? cyc + 12 : -1;
        go(OP_MOVE, sb);
        chk("busy", {bz, busy}, 2'b10);
        if (it) begin
            chk("stop", fl, 3'b010);
            apb(1'b0, REG_PROG_OFF, 0);
            sv = (nw - w0) | ((nw - w0) >= n ? 'h1000 : 0);
            chk("saved", rd, sv);
            apb(1'b1, REG_CTRL_OFF, 1);
            go(OP_MOVE, sb);
            apb(1'b1, REG_CTRL_OFF, 0);
        end
        chk("done", fl, 3'b001);
        for (i = 0; i <= l2; i++)
            chk("dst", bfm_store_inst.mem[b + i], ex[i]);
        chk("cond", cond, (sb == 2 || l1 <= l2) && zn == 2 && !d ? COND_NEG : COND_POS);
        apb(1'b0, REG_PROG_OFF, 0);
        sv = (sv & 'h1000) | (sb == 2 && zn == 3 ? 'h4000 : 0);
        chk("count", rd, (sb != 0 ? l2 : n) | sv);
        $display("move %0d %0d ended", l1, l2);
    endtask
    ////////////////////////////////////////
    initial begin
        void'($urandom(49246));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        apb(1'b1, REG_COND_OFF, 3);
        apb(1'b0, REG_COND_OFF, 0);
        chk("cond_ro", rd, 0);
        apb(1'b0, 8'h10, 0);
        chk("unmapped", rd, 32'hEEEEEEEE);
        apb(1'b1, REG_PROG_OFF, 32'h7FFF);
        apb(1'b0, REG_PROG_OFF, 0);
        chk("prog_rw", rd, 32'h7FFF);
        go(OP_CONV, SUB_TO_BIN);
        apb(1'b0, REG_PROG_OFF, 0);
        chk("conv", rd, 0);
        msw <= 1'b0;
        go(OP_MOVE, SUB_PLAIN);
        chk("trap", fl, 3'b100);
        go(OP_UNIT, SUB_LOAD);
        chk("unit", fl, 3'b001);
        msw <= 1'b1;
        $display("registers and traps ended");
        for (int z = 0; z < 4; z++)
            mv(SUB_PLAIN, 0, 5, 7, 2'(z), 2'(3 - z), 2'(z), 0);
        mv(SUB_PLAIN, 0, 9, 4, 1, 0, 2, 0);
        mv(SUB_BLANK, 0, 3, 8, 2, 1, 2, 0);
        apb(1'b0, REG_STAT_OFF, 0);
        chk("packed", rd[6:3], PACK_NEG);
        mv(SUB_ZERO, 0, 6, 3, 3, 2, 3, 0);
        go(OP_CONV, SUB_PACK);
        apb(1'b0, REG_PROG_OFF, 0);
        chk("pack_keep", rd, 32'h4003);
        mv(SUB_PLAIN, 1, 4, 10, 1, 1, 2, 0);
        slow <= 1'b1;
        iw <= 1'b1;
        mv(SUB_PLAIN, 0, 30, 30, 1, 2, 2, 1);
        mv(SUB_BLANK, 0, 1, 30, 0, 0, 0, 1);
        go(OP_CONV, SUB_PACK);
        apb(1'b0, REG_PROG_OFF, 0);
        chk("pack_restart", rd, 0);
        finish_test;
    end
endmodule
`default_nettype wire

// ===== sim/bfm_store.sv
/* Character storage model standing in for core storage behind the engine.
   Assumes requests are held until acknowledged, all on one clock. */
`timescale 1ns/1ps
`default_nettype none
module bfm_store (
    // Clock and pacing.
    input wire logic clk,
    input wire logic slow,
    // Request side.
    input wire logic req,
    input wire logic we,
    input wire logic [17:0] addr,
    input wire logic [5:0] wdata,
    // Answer side.
    output logic [5:0] rdata,
    output logic ack
);
    logic [5:0] mem [4096];
    logic [5:0] last = 6'h00;
    logic [1:0] wt = 2'h0;
    initial begin
        foreach (mem[i]) mem[i] = 6'h00;
    end
    ////////////////////////////////////////
    // Read data is only valid with the acknowledge; it shows junk otherwise.
    always @(posedge clk) begin
        ack <= 1'b0;
        rdata <= ~last;
        wt <= 2'h0;
        if (req && !ack) begin
            wt <= wt + 2'h1;
            if (!slow || wt == 2'h2) begin
                ack <= 1'b1;
                if (we)
                    mem[addr[11:0]] <= wdata;
                else
                    rdata <= mem[addr[11:0]];
                last <= we ? last : mem[addr[11:0]];
            end
        end
    end
endmodule
`default_nettype wire
